// file: rtl/apb_bridge_dma_arbiter.sv
// AHB slave to peripheral bus bridge with DMA arbitration and lockout control.
`default_nettype none
module apb_bridge_dma_arbiter
  import apb_bridge_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_hsel,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [ADDR_W-1:0] i_haddr,
  input wire logic [DATA_W-1:0] i_hwdata,
  input wire logic i_hreadyin,
  output logic o_hready,
  output logic [DATA_W-1:0] o_hrdata,
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [ADDR_W-1:0] o_paddr,
  output logic [DATA_W-1:0] o_pwdata,
  input wire logic [DATA_W-1:0] i_prdata,
  input wire logic i_pready,
  input wire logic i_cmd_wr,
  input wire logic [CMD_W-1:0] i_cmd_idx,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_data,
  input wire logic i_cmd_write,
  input wire logic i_cmd_last,
  input wire logic [CMD_W-1:0] i_cmd_next,
  input wire logic i_chan_start,
  input wire logic [CHAN_W-1:0] i_chan_id,
  input wire logic [CMD_W-1:0] i_start_idx,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic [CHAN_W-1:0] o_rd_chan,
  output logic [CHAN_N-1:0] o_chan_done,
  output logic [CHAN_N-1:0] o_active
);
  typedef struct packed {
    pio_state_t pio;
    logic [ADDR_W-1:0] pio_addr;
    logic pio_write;
    logic [DATA_W-1:0] pio_wdata;
    logic hready;
    logic [DATA_W-1:0] hrdata;
    bus_state_t bus;
    logic owner_pio;
    logic [LOCK_W-1:0] lockout;
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } bridge_state_t;

  bridge_state_t s;
  bridge_state_t n;
  logic dma_req;
  logic [ADDR_W-1:0] dma_addr;
  logic dma_write;
  logic [DATA_W-1:0] dma_wdata;
  logic dma_done;
  logic pio_want;

  dma_channel_engine u_dma (
    .i_ref_clk(i_ref_clk),
    .i_rstn(i_rstn),
    .i_cmd_wr(i_cmd_wr),
    .i_cmd_idx(i_cmd_idx),
    .i_cmd_addr(i_cmd_addr),
    .i_cmd_data(i_cmd_data),
    .i_cmd_write(i_cmd_write),
    .i_cmd_last(i_cmd_last),
    .i_cmd_next(i_cmd_next),
    .i_chan_start(i_chan_start),
    .i_chan_id(i_chan_id),
    .i_start_idx(i_start_idx),
    .i_done(dma_done),
    .i_rdata(i_prdata),
    .o_req(dma_req),
    .o_addr(dma_addr),
    .o_write(dma_write),
    .o_wdata(dma_wdata),
    .o_rd_valid(o_rd_valid),
    .o_rd_data(o_rd_data),
    .o_rd_chan(o_rd_chan),
    .o_chan_done(o_chan_done),
    .o_active(o_active)
  );

  assign pio_want = (s.pio == PIO_WAIT);

  always_comb begin
    n = s;
    dma_done = 1'b0;
    case (s.pio)
      PIO_IDLE: begin
        if (i_hsel && i_htrans[1] && i_hreadyin) begin
          n.pio = PIO_DATA;
          n.pio_addr = i_haddr;
          n.pio_write = i_hwrite;
          n.hready = 1'b0;
        end
      end
      PIO_DATA: begin
        n.pio_wdata = i_hwdata;
        n.pio = PIO_WAIT;
      end
      PIO_WAIT: begin
        n.pio = PIO_WAIT;
      end
      default: begin
        n.pio = PIO_IDLE;
      end
    endcase
    case (s.bus)
      BUS_IDLE: begin
        // A processor that has lost three times in a row is served next.
        if (pio_want && (!dma_req || s.lockout == LOCKOUT_MAX)) begin
          n.owner_pio = 1'b1;
          n.lockout = '0;
          n.bus = BUS_SETUP;
          n.psel = 1'b1;
          n.pwrite = s.pio_write;
          n.paddr = s.pio_addr;
          n.pwdata = s.pio_wdata;
        end else if (dma_req) begin
          n.owner_pio = 1'b0;
          if (pio_want) begin
            n.lockout = s.lockout + LOCKOUT_ONE;
          end
          n.bus = BUS_SETUP;
          n.psel = 1'b1;
          n.pwrite = dma_write;
          n.paddr = dma_addr;
          n.pwdata = dma_wdata;
        end
      end
      BUS_SETUP: begin
        n.penable = 1'b1;
        n.bus = BUS_ACCESS;
      end
      BUS_ACCESS: begin
        if (i_pready) begin
          n.psel = 1'b0;
          n.penable = 1'b0;
          n.bus = BUS_IDLE;
          if (s.owner_pio) begin
            n.hrdata = i_prdata;
            n.hready = 1'b1;
            n.pio = PIO_IDLE;
          end else begin
            dma_done = 1'b1;
          end
        end
      end
      default: begin
        n.bus = BUS_IDLE;
      end
    endcase
  end

  // Both ports share this one clock, so no synchroniser sits between them.
  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
      s.hready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign o_hready = s.hready;
  assign o_hrdata = s.hrdata;
  assign o_psel = s.psel;
  assign o_penable = s.penable;
  assign o_pwrite = s.pwrite;
  assign o_paddr = s.paddr;
  assign o_pwdata = s.pwdata;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  property p_hready_low;
    s.pio != PIO_IDLE |-> !o_hready;
  endproperty
  a_hready_low: assert property (p_hready_low)
    else $error("HREADY high while a processor access is pending");

  property p_hready_release;
    s.bus == BUS_ACCESS && i_pready && s.owner_pio
      |=> o_hready && o_hrdata == $past(i_prdata) && !o_psel;
  endproperty
  a_hready_release: assert property (p_hready_release)
    else $error("HREADY not released with read data after transfer");

  property p_dma_first;
    s.bus == BUS_IDLE && pio_want && dma_req && s.lockout != LOCKOUT_MAX
      |=> o_psel && !s.owner_pio && o_paddr == $past(dma_addr);
  endproperty
  a_dma_first: assert property (p_dma_first)
    else $error("DMA not favoured on contention");

  property p_force_pio;
    s.bus == BUS_IDLE && pio_want && s.lockout == LOCKOUT_MAX
      |=> o_psel && s.owner_pio && s.lockout == '0;
  endproperty
  a_force_pio: assert property (p_force_pio)
    else $error("Processor not granted after three lockouts");

  property p_lock_count;
    s.bus == BUS_IDLE && pio_want && dma_req && s.lockout != LOCKOUT_MAX
      |=> s.lockout == $past(s.lockout) + LOCKOUT_ONE;
  endproperty
  a_lock_count: assert property (p_lock_count)
    else $error("Lockout count did not step on a processor loss");

  property p_pio_grant_clear;
    s.bus == BUS_IDLE && pio_want && !dma_req |=> s.lockout == '0;
  endproperty
  a_pio_grant_clear: assert property (p_pio_grant_clear)
    else $error("Lockout count not cleared on processor grant");

  property p_bus_phase;
    o_psel && !o_penable |=> o_psel && o_penable && $stable(o_paddr)
      && $stable(s.owner_pio);
  endproperty
  a_bus_phase: assert property (p_bus_phase)
    else $error("Peripheral setup phase not followed by access phase");

  // At most four DMA transfers may go first (one granted before PIO_WAIT, then three lockouts), so a bounded window suffices.
  property p_pio_convert;
    s.pio == PIO_DATA |-> ##[2:1000] (o_psel && !o_penable && s.owner_pio
      && o_paddr == s.pio_addr && o_pwrite == s.pio_write);
  endproperty
  a_pio_convert: assert property (p_pio_convert)
    else $error("Processor access not issued on the peripheral bus");

  c_contention: cover property (pio_want && dma_req && s.bus == BUS_IDLE);
  c_forced: cover property (s.lockout == LOCKOUT_MAX && pio_want && dma_req
                            && s.bus == BUS_IDLE);
  c_pio_read: cover property (s.owner_pio && s.bus == BUS_ACCESS && i_pready
                              && !s.pwrite);
endmodule
`default_nettype wire

// file: rtl/apb_bridge_pkg.sv
// Shared constants and types for the peripheral bus bridge and its arbiter.
// Functional notes
// - The peripheral bus runs on the same clock as the AHB port, with no crossing between them.
// - Every AHB slave access from the processor becomes one peripheral bus transfer.
// - DMA and processor share the one peripheral bus and an arbiter grants it to one of them at a time.
// - When both request together the DMA engine normally wins.
// - While a processor access waits, HREADY stays low until its peripheral transfer is complete.
// - Lockouts of the processor are tracked so it gets at least every fifth transfer under full DMA load.
// - Sixteen DMA channels share one DMA engine and appear to the arbiter as a single requester.
// - Each channel walks its own chained command list and fetches the next command when one ends.
`default_nettype none
package apb_bridge_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int CHAN_N = 16;
  localparam int CHAN_W = 4;
  localparam int CMD_DEPTH = 64;
  localparam int CMD_W = 6;
  localparam int LOCK_W = 2;
  localparam logic [LOCK_W-1:0] LOCKOUT_MAX = 2'h3;
  localparam logic [LOCK_W-1:0] LOCKOUT_ONE = 2'h1;
  localparam logic [CHAN_W-1:0] CHAN_ONE = 4'h1;

  typedef enum logic [1:0] {PIO_IDLE, PIO_DATA, PIO_WAIT} pio_state_t;
  typedef enum logic [1:0] {BUS_IDLE, BUS_SETUP, BUS_ACCESS} bus_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic write;
    logic last;
    logic [CMD_W-1:0] next;
  } cmd_t;
endpackage
`default_nettype wire

// file: rtl/dma_channel_engine.sv
// Sixteen-channel DMA engine walking chained command lists as one requester.
`default_nettype none
module dma_channel_engine
  import apb_bridge_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  input wire logic i_cmd_wr,
  input wire logic [CMD_W-1:0] i_cmd_idx,
  input wire logic [ADDR_W-1:0] i_cmd_addr,
  input wire logic [DATA_W-1:0] i_cmd_data,
  input wire logic i_cmd_write,
  input wire logic i_cmd_last,
  input wire logic [CMD_W-1:0] i_cmd_next,
  input wire logic i_chan_start,
  input wire logic [CHAN_W-1:0] i_chan_id,
  input wire logic [CMD_W-1:0] i_start_idx,
  input wire logic i_done,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic o_req,
  output logic [ADDR_W-1:0] o_addr,
  output logic o_write,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_rd_valid,
  output logic [DATA_W-1:0] o_rd_data,
  output logic [CHAN_W-1:0] o_rd_chan,
  output logic [CHAN_N-1:0] o_chan_done,
  output logic [CHAN_N-1:0] o_active
);
  typedef struct packed {
    logic [CHAN_N-1:0] active;
    logic [CHAN_N-1:0][CMD_W-1:0] ptr;
    logic [CHAN_W-1:0] rr;
    logic [CHAN_W-1:0] cur;
    logic req;
    cmd_t cmd;
    logic rd_valid;
    logic [DATA_W-1:0] rd_data;
    logic [CHAN_W-1:0] rd_chan;
    logic [CHAN_N-1:0] chan_done;
  } dma_state_t;

  cmd_t table_mem [CMD_DEPTH];
  dma_state_t s;
  dma_state_t n;

  // Round-robin pick of the next active channel, starting at rr.
  function automatic logic [CHAN_W:0] pick(input logic [CHAN_N-1:0] act,
                                           input logic [CHAN_W-1:0] rr);
    logic [CHAN_W-1:0] idx;
    pick = '0;
    for (int k = CHAN_N - 1; k >= 0; k--) begin
      idx = rr + CHAN_W'(k);
      if (act[idx]) begin
        pick = {1'b1, idx};
      end
    end
  endfunction

  always_ff @(posedge i_ref_clk) begin
    if (i_cmd_wr) begin
      table_mem[i_cmd_idx] <= {i_cmd_addr, i_cmd_data, i_cmd_write,
                               i_cmd_last, i_cmd_next};
    end
  end

  // A finishing command hands over to the next channel in the same cycle,
  // so the request never drops under continuous demand and a waiting
  // processor really meets contention at the arbiter.
  always_comb begin
    logic [CHAN_W:0] sel;
    logic free;
    sel = '0;
    free = !s.req;
    n = s;
    n.rd_valid = 1'b0;
    n.chan_done = '0;
    if (s.req && i_done) begin
      free = 1'b1;
      n.req = 1'b0;
      n.rr = s.cur + CHAN_ONE;
      n.rd_valid = !s.cmd.write;
      n.rd_data = i_rdata;
      n.rd_chan = s.cur;
      if (s.cmd.last) begin
        n.active[s.cur] = 1'b0;
        n.chan_done[s.cur] = 1'b1;
      end else begin
        n.ptr[s.cur] = s.cmd.next;
      end
    end
    sel = pick(n.active, n.rr);
    if (free && sel[CHAN_W]) begin
      n.req = 1'b1;
      n.cur = sel[CHAN_W-1:0];
      n.cmd = table_mem[n.ptr[sel[CHAN_W-1:0]]];
    end
    if (i_chan_start && !s.active[i_chan_id]) begin
      n.active[i_chan_id] = 1'b1;
      n.ptr[i_chan_id] = i_start_idx;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign o_req = s.req;
  assign o_addr = s.cmd.addr;
  assign o_write = s.cmd.write;
  assign o_wdata = s.cmd.data;
  assign o_rd_valid = s.rd_valid;
  assign o_rd_data = s.rd_data;
  assign o_rd_chan = s.rd_chan;
  assign o_chan_done = s.chan_done;
  assign o_active = s.active;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rstn);

  property p_req_hold;
    s.req && !i_done |=> s.req && $stable(s.cmd) && $stable(s.cur);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("DMA request dropped or changed before completion");

  property p_chain_next;
    s.req && i_done && !s.cmd.last
      |=> s.active[$past(s.cur)] && s.ptr[$past(s.cur)] == $past(s.cmd.next);
  endproperty
  a_chain_next: assert property (p_chain_next)
    else $error("Channel did not advance to its next command");

  property p_chain_end;
    s.req && i_done && s.cmd.last |=> $onehot(o_chan_done)
      && o_chan_done[$past(s.cur)] && !s.active[$past(s.cur)];
  endproperty
  a_chain_end: assert property (p_chain_end)
    else $error("Last command did not retire its channel");

  c_chain: cover property (s.req && i_done && !s.cmd.last);
endmodule
`default_nettype wire

// file: dv/apb_slave_model.sv
// Peripheral bus slave model with optional wait states.
`default_nettype none
module apb_slave_model
  import apb_bridge_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [ADDR_W-1:0] i_paddr,
  input wire logic [DATA_W-1:0] i_pwdata,
  input wire logic i_slow,
  output logic o_pready,
  output logic [DATA_W-1:0] o_prdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [DATA_W-1:0] mem [16];
  logic [1:0] cnt = 2'h0;
  wire logic [3:0] idx = i_paddr[5:2];
  assign o_pready = i_psel & i_penable & (cnt == 2'h0);
  // Read data is only good with ready; otherwise its inverse shows.
  assign o_prdata = o_pready ? mem[idx] : ~mem[idx];
  always @(posedge i_ref_clk) begin
    if (i_psel & !i_penable) cnt <= i_slow ? 2'h2 : 2'h0;
    else if (cnt != 2'h0) cnt <= cnt - 2'h1;
    if (o_pready & i_pwrite) mem[idx] <= i_pwdata;
  end
endmodule
`default_nettype wire

// file: dv/tb_apb_bridge_dma_arbiter.sv
// Self-checking bench for the bridge, its arbiter and the DMA engine.
`default_nettype none
module tb_apb_bridge_dma_arbiter;
  import apb_bridge_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic i_ref_clk = 1'b0, i_rstn = 1'b0, i_hsel = 1'b0, i_hwrite = 1'b0;
  logic i_hreadyin = 1'b1, i_cmd_wr = 1'b0, i_cmd_write = 1'b0;
  logic i_cmd_last = 1'b0, i_chan_start = 1'b0, slow = 1'b0;
  logic [1:0] i_htrans = 2'h0;
  logic [ADDR_W-1:0] i_haddr = '0, i_cmd_addr = '0;
  logic [DATA_W-1:0] i_hwdata = '0, i_cmd_data = '0;
  logic [CMD_W-1:0] i_cmd_idx = '0, i_cmd_next = '0, i_start_idx = '0;
  logic [CHAN_W-1:0] i_chan_id = '0;
  wire logic o_hready, o_psel, o_penable, o_pwrite, i_pready, o_rd_valid;
  wire logic [ADDR_W-1:0] o_paddr;
  wire logic [DATA_W-1:0] o_hrdata, o_pwdata, i_prdata, o_rd_data;
  wire logic [CHAN_W-1:0] o_rd_chan;
  wire logic [CHAN_N-1:0] o_chan_done, o_active;
  logic [DATA_W-1:0] pq [$], dq [$], d [16];
  logic [CHAN_N-1:0] done_seen = '0;
  logic psel_q = 1'b0, hready_q = 1'b1;
  logic rq [$];
  logic [CHAN_W-1:0] cq [$];
  int errors = 0, total_checks = 0, seed = 96, lowc = 0, lost = 0;
  int hit3 = 0, contended = 0;

  apb_bridge_dma_arbiter apb_bridge_dma_arbiter_inst (.i_ref_clk, .i_rstn,
    .i_hsel, .i_htrans, .i_hwrite, .i_haddr, .i_hwdata, .i_hreadyin,
    .o_hready, .o_hrdata, .o_psel, .o_penable, .o_pwrite, .o_paddr,
    .o_pwdata, .i_prdata, .i_pready, .i_cmd_wr, .i_cmd_idx, .i_cmd_addr,
    .i_cmd_data, .i_cmd_write, .i_cmd_last, .i_cmd_next, .i_chan_start,
    .i_chan_id, .i_start_idx, .o_rd_valid, .o_rd_data, .o_rd_chan,
    .o_chan_done, .o_active);
  apb_slave_model apb_slave_model_inst (.i_ref_clk, .i_psel(o_psel),
    .i_penable(o_penable), .i_pwrite(o_pwrite), .i_paddr(o_paddr),
    .i_pwdata(o_pwdata), .i_slow(slow), .o_pready(i_pready),
    .o_prdata(i_prdata));

  initial begin
    forever #4 i_ref_clk = ~i_ref_clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic fail_to();
    errors++;
    $display("[FAIL] %0t wait ran out", $time);
    end_sim();
  endtask

  task automatic tick();
    @(posedge i_ref_clk);
    #1;
  endtask

  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] wd);
    int n;
    i_hsel = 1'b1;
    i_htrans = 2'h2;
    i_hwrite = w;
    i_haddr = a;
    rq.push_back(!w);
    tick();
    i_hsel = 1'b0;
    i_htrans = 2'h0;
    i_hwdata = wd;
    n = 1;
    check(o_hready, 1'b0);
    while (o_hready !== 1'b1) begin
      tick();
      n++;
      if (n > 400) fail_to();
    end
    check(n >= 5, 1'b1);
  endtask

  task automatic cmd(input logic [CMD_W-1:0] ix, input logic [31:0] a,
    input logic [31:0] dd, input logic w, input logic l,
    input logic [CMD_W-1:0] nx);
    i_cmd_wr = 1'b1;
    i_cmd_idx = ix;
    i_cmd_addr = a;
    i_cmd_data = dd;
    i_cmd_write = w;
    i_cmd_last = l;
    i_cmd_next = nx;
    tick();
    i_cmd_wr = 1'b0;
    tick();
  endtask

  task automatic start(input logic [CHAN_W-1:0] ch, input logic [CMD_W-1:0] ix);
    i_chan_start = 1'b1;
    i_chan_id = ch;
    i_start_idx = ix;
    tick();
    i_chan_start = 1'b0;
    tick();
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    while (o_active !== '0) begin
      tick();
      n++;
      if (n > 3000) fail_to();
    end
    repeat (2) tick();
  endtask

  // Arbitration watch: DMA grants made while the processor waits.
  always @(posedge i_ref_clk) begin
    lowc = o_hready ? 0 : lowc + 1;
    if (o_psel && !psel_q && o_paddr[8] && lowc >= 3) begin
      lost++;
      check(lost <= 3, 1'b1);
    end else if (o_psel && !psel_q && !o_paddr[8]) begin
      if (lost == 3) hit3++;
      if (lost > 0) contended++;
      lost = 0;
    end
    if (o_hready && !hready_q && rq.size() > 0) begin
      if (rq.pop_front()) check(o_hrdata, pq.pop_front());
    end
    if (o_rd_valid) begin
      check(o_rd_data, dq.size() ? dq.pop_front() : ~o_rd_data);
      check(o_rd_chan, cq.size() ? cq.pop_front() : ~o_rd_chan);
    end
    done_seen = done_seen | o_chan_done;
    psel_q = o_psel;
    hready_q = o_hready;
  end

  initial begin
    repeat (6) @(posedge i_ref_clk);
    check(o_hready, 1'b1);
    check(o_psel, 1'b0);
    check(o_active, '0);
    #1;
    i_rstn = 1'b1;
    for (int i = 0; i < 8; i++) begin
      d[i] = $random(seed);
      ahb(1'b1, 32'(i * 4), d[i]);
    end
    for (int i = 0; i < 8; i++) begin
      slow = i[0];
      pq.push_back(d[i]);
      ahb(1'b0, 32'(i * 4), '0);
    end
    d[8] = $random(seed);
    cmd(6'h00, 32'h120, d[8], 1'b1, 1'b0, 6'h01);
    cmd(6'h01, 32'h120, '0, 1'b0, 1'b0, 6'h02);
    cmd(6'h02, 32'h100, '0, 1'b0, 1'b1, 6'h00);
    dq.push_back(d[8]);
    dq.push_back(d[0]);
    cq.push_back(4'h5);
    cq.push_back(4'h5);
    start(4'h5, 6'h00);
    check(o_active[5], 1'b1);
    start(4'h5, 6'h00);
    wait_idle();
    check(done_seen[5], 1'b1);
    pq.push_back(d[8]);
    ahb(1'b0, 32'h20, '0);
    cmd(6'h0a, 32'h104, '0, 1'b0, 1'b1, 6'h00);
    done_seen = '0;
    for (int c = 0; c < 16; c++) begin
      dq.push_back(d[1]);
      cq.push_back(4'(c));
      start(4'(c), 6'h0a);
    end
    wait_idle();
    check(done_seen, 16'hffff);
    for (int k = 0; k < 16; k++) begin
      cmd(6'(16 + k), 32'h13c, $random(seed), 1'b1, k == 15, 6'(17 + k));
      cmd(6'(32 + k), 32'h13c, $random(seed), 1'b1, k == 15, 6'(33 + k));
    end
    start(4'h1, 6'h10);
    start(4'h2, 6'h20);
    for (int i = 0; i < 6; i++) begin
      slow = $random(seed);
      pq.push_back(d[i]);
      ahb(1'b0, 32'(i * 4), '0);
    end
    wait_idle();
    check(contended > 0, 1'b1);
    check(hit3 > 0, 1'b1);
    check(dq.size(), '0);
    end_sim();
  end
endmodule
`default_nettype wire
